// ===== verif/airs_chk.sv
// port assertions for the result and input-select block
// assumes only the top module ports are seen; bound at the foot
`timescale 1ns/10ps
module airs_chk
    import airs_pkg::*;
(
    // system
    input wire logic       CLK_SYS,
    input wire logic       RST_B,
    // bus
    input wire logic [6:0] IO_ADDR,
    input wire logic       IO_DATA_SPACE,
    input wire logic [7:0] IO_RDATA,
    // core
    input wire logic       CONV_START,
    input wire logic       CONV_DONE,
    // front end
    input wire logic [2:0] MUX_POS,
    input wire logic [2:0] MUX_NEG,
    input wire logic       MUX_DIFF,
    input wire logic       MUX_BANDGAP,
    input wire logic       MUX_GROUND,
    input wire logic [1:0] GAIN_SEL,
    input wire logic [1:0] REF_SEL,
    input wire logic       REF_INT_EN,
    input wire logic       REF_AVCC_EN,
    input wire logic       BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    wire logic [6:0]  ofs = IO_ADDR - (IO_DATA_SPACE ? AIRS_IO_OFS : 7'h00);
    wire logic        hit = ofs inside {AIRS_SEL_IO, AIRS_RES_LO_IO, AIRS_RES_HI_IO};
    wire logic [12:0] fe = {MUX_POS, MUX_NEG, MUX_DIFF, MUX_BANDGAP, MUX_GROUND, GAIN_SEL, REF_SEL};
    a_busy_rise: assert property (CONV_START |=> BUSY) else $error("busy not set");
    a_busy_fall: assert property (CONV_DONE |=> !BUSY) else $error("busy stuck");
    a_sel_held: assert property (BUSY && $past(BUSY) |-> $stable(fe)) else $error("sel moved");
    a_ref_int: assert property (REF_INT_EN == (REF_SEL == AIRS_REF_INT)) else $error("int ref");
    a_ref_avcc: assert property (REF_AVCC_EN == (REF_SEL == AIRS_REF_AVCC)) else $error("avcc");
    a_gain_diff: assert property (GAIN_SEL != 2'h0 |-> MUX_DIFF) else $error("gain on se");
    a_fixed_src: assert property (MUX_BANDGAP | MUX_GROUND |-> !(MUX_DIFF | MUX_BANDGAP & MUX_GROUND))
        else $error("fixed source");
    a_unmapped_zero: assert property (!$past(hit) |-> IO_RDATA == 8'h00) else $error("unmapped");
    c_conv: cover property (CONV_DONE && BUSY);
    c_gain: cover property (GAIN_SEL == 2'h2);
    c_bandgap: cover property (MUX_BANDGAP);
endmodule
bind airs_top airs_chk i_chk (.CLK_SYS, .RST_B, .IO_ADDR, .IO_DATA_SPACE, .IO_RDATA, .CONV_START,
    .CONV_DONE, .MUX_POS, .MUX_NEG, .MUX_DIFF, .MUX_BANDGAP, .MUX_GROUND, .GAIN_SEL, .REF_SEL,
    .REF_INT_EN, .REF_AVCC_EN, .BUSY);

// ===== verif/airs_core_mdl.sv
// converter core stand-in: start pulse, fixed delay, done with raw
// assumes go is a one-cycle request from the bench
`timescale 1ns/10ps
module airs_core_mdl #(parameter int DLY = 4) (
    // bench side
    input wire logic        clk,
    input wire logic        go,
    input wire logic [10:0] raw,
    // block side
    output logic            start,
    output logic            done,
    output logic     [10:0] raw_out
);
    int          cnt = 0;
    logic [10:0] last = '0;
    always @(posedge clk) begin
        start <= go;
        done <= cnt == 1;
        cnt <= go ? DLY : (cnt > 0 ? cnt - 1 : 0);
        // off the done cycle the bus carries junk, never the last code
        raw_out <= cnt == 1 ? raw : ~last;
        if (cnt == 1)
            last <= raw;
    end
endmodule

// ===== verif/tb.sv
// bench: selection register, decode, layout, clamp, deferral, freeze
// assumes the core stand-in answers after a fixed delay
`timescale 1ns/10ps
module tb;
    logic CLK_SYS = '0, RST_B = '0, IO_DATA_SPACE = '0, IO_WR = '0, IO_RD = '0, go = '0;
    logic [6:0] IO_ADDR = '0;
    logic [7:0] IO_WDATA = '0, IO_RDATA;
    logic [10:0] raw = '0, CONV_RAW;
    logic [2:0] MUX_POS, MUX_NEG;
    logic [1:0] GAIN_SEL, REF_SEL;
    logic CONV_START, CONV_DONE, MUX_DIFF, MUX_BANDGAP, MUX_GROUND, REF_INT_EN, REF_AVCC_EN, BUSY;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    wire logic [12:0] fe = {MUX_POS, MUX_NEG, MUX_DIFF, GAIN_SEL, REF_SEL, REF_INT_EN, REF_AVCC_EN};
    always #50 CLK_SYS = ~CLK_SYS;
    airs_core_mdl i_core (.clk(CLK_SYS), .go, .raw, .start(CONV_START), .done(CONV_DONE),
        .raw_out(CONV_RAW));
    airs_top i_dut (.CLK_SYS, .RST_B, .IO_ADDR, .IO_DATA_SPACE, .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA,
        .CONV_START, .CONV_DONE, .CONV_RAW, .MUX_POS, .MUX_NEG, .MUX_DIFF, .MUX_BANDGAP, .MUX_GROUND,
        .GAIN_SEL, .REF_SEL, .REF_INT_EN, .REF_AVCC_EN, .BUSY);
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            complete_run;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge CLK_SYS);
        #1;
    endtask
    // strobe held for one edge; read data is settled when this returns
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        IO_ADDR = a;
        IO_DATA_SPACE = a[5];
        IO_WDATA = d;
        IO_WR = w;
        IO_RD = !w;
        step;
        IO_WR = '0;
        IO_RD = '0;
        step;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        chk(IO_RDATA, e);
    endtask
    task automatic conv(input logic [10:0] r);
        raw = r;
        go = '1;
        step;
        go = '0;
        repeat (8) step;
    endtask
    task automatic t_example;
        rdc(7'h07, 8'h00);
        acc(1'h1, 7'h27, 8'hED);
        rdc(7'h07, 8'hED);
        chk(fe, 13'h0D5E);
        conv(11'h670);
        rdc(7'h04, 8'h00);
        rdc(7'h05, 8'h9C);
        acc(1'h1, 7'h07, 8'hCD);
        rdc(7'h04, 8'h70);
        rdc(7'h05, 8'h02);
    endtask
    task automatic t_clamp;
        logic [28:0] tv [3] = '{{8'hCD, 11'h258, 10'h1FF}, {8'hCD, 11'h5A8, 10'h200},
            {8'h40, 11'h400, 10'h3FF}};
        foreach (tv[i]) begin
            acc(1'h1, 7'h07, tv[i][28:21]);
            conv(tv[i][20:10]);
            rdc(7'h04, tv[i][7:0]);
            rdc(7'h05, {6'h00, tv[i][9:8]});
        end
    endtask
    task automatic t_defer;
        acc(1'h1, 7'h07, 8'h40);
        go = '1;
        step;
        go = '0;
        step;
        acc(1'h1, 7'h07, 8'h5E);
        chk(MUX_BANDGAP, 1'h0);
        chk(BUSY, 1'h1);
        repeat (6) step;
        chk(BUSY, 1'h0);
        chk({MUX_BANDGAP, fe[6], REF_AVCC_EN}, 3'h5);
    endtask
    task automatic t_freeze;
        conv(11'h0AB);
        rdc(7'h04, 8'hAB);
        conv(11'h155);
        rdc(7'h05, 8'h00);
        conv(11'h2CD);
        rdc(7'h04, 8'hCD);
        rdc(7'h25, 8'h02);
        rdc(7'h03, 8'h00);
        // low read lands on the done edge: the pair must stay the old code
        raw = 11'h1FF;
        go = '1;
        step;
        go = '0;
        repeat (4) step;
        rdc(7'h04, 8'hCD);
        rdc(7'h05, 8'h02);
    endtask
    task automatic t_decode;
        logic [20:0] tv [5] = '{{8'h0A, 13'h0060}, {8'h17, 13'h1CC0}, {8'hDD, 13'h154E},
            {8'h49, 13'h0455}, {8'h80, 13'h0008}};
        foreach (tv[i]) begin
            acc(1'h1, 7'h07, tv[i][20:13]);
            step;
            chk(fe, tv[i][12:0]);
        end
        acc(1'h1, 7'h07, 8'h1F);
        step;
        chk({MUX_DIFF, MUX_BANDGAP, MUX_GROUND}, 3'h1);
    endtask
    initial begin
        repeat (16) step;
        RST_B = '1;
        t_example;
        t_clamp;
        t_defer;
        t_freeze;
        t_decode;
        complete_run;
    end
endmodule

// ===== verilog/airs_fmt.sv
// result byte formatter: places a 10-bit code into two bytes
// assumes the code is already clamped and two's complement where differential
`timescale 1ns/10ps
module airs_fmt
    import airs_pkg::*;
(
    airs_res_if.fmt res
);
    wire [7:0] lj_low  = {res.code[1:0], 6'h00};
    wire [7:0] lj_high = res.code[9:2];
    wire [7:0] rj_low  = res.code[7:0];
    wire [7:0] rj_high = {6'h00, res.code[9:8]};

    // unused positions stay zero either way
    assign res.low_byte  = res.left_justify ? lj_low : rj_low;
    assign res.high_byte = res.left_justify ? lj_high : rj_high;
endmodule

// ===== verilog/airs_pkg.sv
// constants for the converter result and input-select block
// assumes an 8-bit I/O register bus with separate read and write strobes
package airs_pkg;
    localparam logic [6:0] AIRS_IO_OFS      = 7'h20;
    localparam logic [6:0] AIRS_SEL_IO      = 7'h07;
    localparam logic [6:0] AIRS_RES_LO_IO   = 7'h04;
    localparam logic [6:0] AIRS_RES_HI_IO   = 7'h05;
    localparam logic [7:0] AIRS_SEL_RESET   = 8'h00;
    localparam int         AIRS_REF_HI      = 7;
    localparam int         AIRS_REF_LO      = 6;
    localparam int         AIRS_LJ_BIT      = 5;
    localparam int         AIRS_CH_HI       = 4;
    localparam logic [9:0] AIRS_POS_MAX     = 10'h1FF;
    localparam logic [9:0] AIRS_NEG_MIN     = 10'h200;
    localparam logic [9:0] AIRS_SE_MAX      = 10'h3FF;
    localparam logic [4:0] AIRS_CH_DIFF_LO  = 5'h08;
    localparam logic [4:0] AIRS_CH_DIFF_HI  = 5'h1D;
    localparam logic [4:0] AIRS_CH_BANDGAP  = 5'h1E;
    localparam logic [4:0] AIRS_CH_GROUND   = 5'h1F;
    localparam logic [4:0] AIRS_CH_NEG1_LO  = 5'h10;
    localparam logic [4:0] AIRS_CH_NEG2_LO  = 5'h18;
    localparam logic [1:0] AIRS_REF_EXT     = 2'h0;
    localparam logic [1:0] AIRS_REF_AVCC    = 2'h1;
    localparam logic [1:0] AIRS_REF_INT     = 2'h3;
    typedef enum logic [1:0] {
        AIRS_GAIN_1X   = 2'h0,
        AIRS_GAIN_10X  = 2'h1,
        AIRS_GAIN_200X = 2'h2
    } airs_gain_t;
    typedef enum logic [1:0] {
        AIRS_IDLE = 2'h0,
        AIRS_CONV = 2'h1,
        AIRS_HOLD = 2'h3
    } airs_state_t;
endpackage

// ===== verilog/airs_res_if.sv
// carries the formatted result bytes from the formatter to the top
// assumes both ends run on the system clock
`timescale 1ns/10ps
interface airs_res_if;
    logic [9:0] code;
    logic       left_justify;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    modport fmt (input code, input left_justify, output low_byte, output high_byte);
    modport top (output code, output left_justify, input low_byte, input high_byte);
endinterface

// ===== verilog/airs_top.sv
// converter result presentation and input selection
// assumes an I/O register bus from the CPU core and a converter core that
// flags start and completion with one-cycle pulses, handing a raw code
//
// Behaviour
// - result bytes readable after conversion complete
// - single-ended gives unsigned 10-bit code
// - differential gives signed two's-complement code
// - bit 9 carries differential sign
// - differential codes clamp at full scale
// - left-justify bit picks byte layout
// - layout change applies immediately
// - decode two-bit reference field
// - selections latched per conversion
// - decode single-ended, bandgap, ground codes
// - decode gain pairs 10x and 200x
// - decode unity-gain pairs on negatives 1, 2
// - same-pin pair codes allowed for offset
// - register at I/O 0x07 and data 0x27
// - low-byte read freezes until high read
// - bit placement in high and low bytes
`timescale 1ns/10ps
module airs_top
    import airs_pkg::*;
(
    // system
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // register bus
    input  wire logic [6:0]  IO_ADDR,
    input  wire logic        IO_DATA_SPACE,
    input  wire logic        IO_WR,
    input  wire logic        IO_RD,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA,
    // converter core
    input  wire logic        CONV_START,
    input  wire logic        CONV_DONE,
    input  wire logic [10:0] CONV_RAW,
    // analog front end
    output logic      [2:0]  MUX_POS,
    output logic      [2:0]  MUX_NEG,
    output logic             MUX_DIFF,
    output logic             MUX_BANDGAP,
    output logic             MUX_GROUND,
    output logic      [1:0]  GAIN_SEL,
    output logic      [1:0]  REF_SEL,
    output logic             REF_INT_EN,
    output logic             REF_AVCC_EN,
    output logic             BUSY
);
    airs_res_if res ();

    logic [7:0]  sel_r;
    logic [7:0]  act_r;
    logic [9:0]  code_r;
    logic [9:0]  code_nxt;
    logic        frozen_r;
    airs_state_t state_r;
    airs_state_t state_nxt;
    logic [7:0]  rdata_nxt;

    // short I/O and data-space forms decode to the same place
    wire [6:0] io_addr = IO_DATA_SPACE ? IO_ADDR - AIRS_IO_OFS : IO_ADDR;
    wire       hit_sel = io_addr == AIRS_SEL_IO;
    wire       hit_lo  = io_addr == AIRS_RES_LO_IO;
    wire       hit_hi  = io_addr == AIRS_RES_HI_IO;
    wire       wr_sel  = IO_WR && hit_sel;
    wire       rd_lo   = IO_RD && hit_lo;
    wire       rd_hi   = IO_RD && hit_hi;

    // a write mid-conversion waits in sel_r until the done pulse
    wire       load_act = (state_r == AIRS_IDLE) || CONV_DONE;
    wire [7:0] act_nxt  = load_act ? (wr_sel ? IO_WDATA : sel_r) : act_r;

    // decode the value act_r takes at this edge, so the front-end controls
    // switch together with it and never lag a conversion start by a cycle
    wire [4:0] ch      = act_nxt[AIRS_CH_HI:0];
    wire       is_se   = ch < AIRS_CH_DIFF_LO;
    wire       is_bg   = ch == AIRS_CH_BANDGAP;
    wire       is_gnd  = ch == AIRS_CH_GROUND;
    wire       is_diff = (ch >= AIRS_CH_DIFF_LO) && (ch <= AIRS_CH_DIFF_HI);
    wire       is_gain = ch < AIRS_CH_NEG1_LO;
    // gain codes: bit 2 picks negative 0 or 2, bit 0 the upper input, bit 1 gain
    wire [2:0] gain_pos = {1'b0, ch[2], ch[0]};
    wire [2:0] gain_neg = {1'b0, ch[2], 1'b0};
    wire       neg2     = ch >= AIRS_CH_NEG2_LO;
    wire [2:0] pos_nxt  = is_se ? ch[2:0] : (is_gain ? gain_pos : ch[2:0]);
    wire [2:0] neg_nxt  = is_gain ? gain_neg : (neg2 ? 3'h2 : 3'h1);
    wire [1:0] gain_nxt = !is_gain || is_se ? AIRS_GAIN_1X
                        : (ch[1] ? AIRS_GAIN_200X : AIRS_GAIN_10X);
    wire [1:0] ref_nxt  = act_nxt[AIRS_REF_HI:AIRS_REF_LO];

    // raw core value is signed 11 bits for differential so clamping can act
    wire signed [10:0] raw_s = CONV_RAW;
    wire       over   = raw_s > $signed({1'b0, AIRS_POS_MAX});
    wire       under  = raw_s < -$signed({1'b0, AIRS_NEG_MIN});
    wire [9:0] diff_c = over ? AIRS_POS_MAX
                      : (under ? AIRS_NEG_MIN : CONV_RAW[9:0]);
    wire [9:0] se_c   = CONV_RAW[10] ? AIRS_SE_MAX : CONV_RAW[9:0];
    // MUX_DIFF holds the decode of act_r, the selection of this conversion
    wire [9:0] conv_c = MUX_DIFF ? diff_c : se_c;

    // freeze after low read blocks the update until the high read
    // a done pulse in the cycle of the low read is dropped as well: the low
    // byte just taken comes from the old code
    wire       upd    = CONV_DONE && !frozen_r && !rd_lo;
    assign code_nxt   = upd ? conv_c : code_r;
    wire       frozen_nxt = rd_lo || (frozen_r && !rd_hi);
    wire [7:0] sel_nxt    = wr_sel ? IO_WDATA : sel_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AIRS_IDLE: if (CONV_START) state_nxt = AIRS_CONV;
            AIRS_CONV: if (CONV_DONE) state_nxt = AIRS_HOLD;
            AIRS_HOLD: state_nxt = CONV_START ? AIRS_CONV : AIRS_IDLE;
            default:   state_nxt = AIRS_IDLE;
        endcase
    end

    // layout follows sel_r live, not the latched copy
    assign res.code         = code_r;
    assign res.left_justify = sel_r[AIRS_LJ_BIT];
    airs_fmt u_fmt (.res(res.fmt));

    assign rdata_nxt = hit_sel ? sel_r
                     : hit_lo ? res.low_byte
                     : hit_hi ? res.high_byte : 8'h00;

    // selection register as software sees it
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sel_r <= AIRS_SEL_RESET;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // copy that steers the front end; held while converting
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            act_r <= AIRS_SEL_RESET;
        end else begin
            act_r <= act_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            code_r <= 10'h000;
        end else begin
            code_r <= code_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            frozen_r <= 1'b0;
        end else begin
            frozen_r <= frozen_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state_r <= AIRS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read data follows the address alone; the read strobe only sets and clears the freeze and drops a done pulse that meets a low read
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            IO_RDATA <= 8'h00;
        end else begin
            IO_RDATA <= rdata_nxt;
        end
    end

    // front-end controls change at the same edge as act_r
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            MUX_POS     <= 3'h0;
            MUX_NEG     <= 3'h0;
            MUX_DIFF    <= 1'b0;
            MUX_BANDGAP <= 1'b0;
            MUX_GROUND  <= 1'b0;
        end else begin
            MUX_POS     <= pos_nxt;
            MUX_NEG     <= neg_nxt;
            MUX_DIFF    <= is_diff;
            MUX_BANDGAP <= is_bg;
            MUX_GROUND  <= is_gnd;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            GAIN_SEL    <= AIRS_GAIN_1X;
            REF_SEL     <= AIRS_REF_EXT;
            REF_INT_EN  <= 1'b0;
            REF_AVCC_EN <= 1'b0;
        end else begin
            GAIN_SEL    <= gain_nxt;
            REF_SEL     <= ref_nxt;
            // reserved code 10 enables neither source
            REF_INT_EN  <= ref_nxt == AIRS_REF_INT;
            REF_AVCC_EN <= ref_nxt == AIRS_REF_AVCC;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= state_nxt == AIRS_CONV;
        end
    end
endmodule
